// [hw/fsp_consts.svh]
/*
  Constants of the flash self-programming sequencer.
  Assumes one 10 MHz system clock and a synchronous flash array port.
*/
// Functional notes
// [RL1] Rows hold 64 words, 192 bytes
// [RL2] Page erase covers eight rows, 512 words
// [RL3] Rows and pages aligned from address zero
// [RL4] Row programming takes data from holding buffer
// [RL5] Software loads buffer within one aligned row
// [RL6] Software issues 64 low/high table writes
// [RL7] Table write finishes in two cycles
// [RL8] Only a started cycle changes the array
// [RL9] Processor stalls while operation runs
// [RL10] Durations counted from fast RC cycle figures
// [RL11] Start bit 15 clears itself when done
// [RL12] Software writes 0x55 then 0xAA key
// [RL13] Key register is write-only, reads zero
// [RL14] Control register selects operation and start
// [RL15] Address is page byte over 16-bit offset
// [RL16] Low table access covers bits 15:0
// [RL17] High table access covers bits 23:16
// [RL18] Single word programming is supported
// [RL19] Works during normal run, no special mode
// [RL20] External serial programming lives outside block
// [RL21] Enable bit 14 gates every operation
// [RL22] Error flag 13 marks improper sequence
// [RL23] Erase codes: 1111 bulk, 0010 page, 0000 cfg
// [RL24] Program codes: 0011 word, 0001 row
// [RL25] Start valid only right after both keys
`ifndef FSP_CONSTS_SVH
`define FSP_CONSTS_SVH
`define FSP_REG_CTL     2'h0
`define FSP_REG_KEY     2'h1
`define FSP_REG_PAGE    2'h2
`define FSP_CTL_START   15
`define FSP_CTL_EN      14
`define FSP_CTL_ERR     13
`define FSP_CTL_ERASE   6
`define FSP_KEY_FIRST   8'h55
`define FSP_KEY_SECOND  8'haa
`define FSP_OPC_BULK    4'hf
`define FSP_OPC_PAGE    4'h2
`define FSP_OPC_CFG     4'h0
`define FSP_OPC_WORD    4'h3
`define FSP_OPC_ROW     4'h1
`define FSP_LAST_IDX    6'h3f
`define FSP_ROW_MASK    24'hffff80
`define FSP_PAGE_MASK   24'hfffc00
`define FSP_FRC_KHZ     7370
`define FSP_SYS_KHZ     10000
`define FSP_ROW_FRC_CYC 11064
`define FSP_CYC(f)      (((f) * `FSP_SYS_KHZ + `FSP_FRC_KHZ - 1) / `FSP_FRC_KHZ)
`endif

// [hw/fsp_pkg.sv]
/*
  Types of the flash self-programming sequencer.
  Assumes fsp_consts.svh is on the include path.
*/
`default_nettype none
`include "fsp_consts.svh"
package fsp_pkg;
  typedef enum logic [2:0] {
    FSP_OP_NONE = 3'h0, FSP_OP_BULK = 3'h1, FSP_OP_PAGE = 3'h2, FSP_OP_CFG_ERASE = 3'h3,
    FSP_OP_WORD = 3'h4, FSP_OP_ROW = 3'h5, FSP_OP_CFG_PROG = 3'h6
  } fsp_op_t;
  typedef enum logic [3:0] {
    FSP_ST_IDLE = 4'h1, FSP_ST_STREAM = 4'h2, FSP_ST_ERASE = 4'h4, FSP_ST_WAIT = 4'h8
  } fsp_state_t;
  typedef struct packed {
    logic        rd;
    logic        we;
    logic        erase;
    fsp_op_t     op;
    logic [23:0] addr;
    logic [23:0] wdata;
  } fsp_arr_cmd_t;
  typedef struct packed {
    logic        req;
    logic        write;
    logic        high;
    logic        byte_mode;
    logic [15:0] ea;
    logic [15:0] wdata;
  } fsp_tbl_req_t;
  // Operation select decode, used by the control register write logic
  function automatic fsp_op_t fsp_decode(input logic erase, input logic [3:0] code);
    fsp_op_t r;
    r = FSP_OP_NONE;
    if (erase)
    begin
      if (code == `FSP_OPC_BULK) r = FSP_OP_BULK;
      else if (code == `FSP_OPC_PAGE) r = FSP_OP_PAGE;
      else if (code == `FSP_OPC_CFG) r = FSP_OP_CFG_ERASE;
    end
    else
    begin
      if (code == `FSP_OPC_WORD) r = FSP_OP_WORD;
      else if (code == `FSP_OPC_ROW) r = FSP_OP_ROW;
      else if (code == `FSP_OPC_CFG) r = FSP_OP_CFG_PROG;
    end
    return r;
  endfunction
endpackage
`default_nettype wire

// [hw/fsp_keyguard.sv]
/*
  Unlock key tracker: arms on the first key, unlocks on the second.
  Assumes every register write is seen on wr_any, one cycle each.
*/
`default_nettype none
`include "fsp_consts.svh"
module fsp_keyguard (
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  input  wire logic       wr_any,
  input  wire logic       wr_key,
  input  wire logic [7:0] wdata,
  output logic            unlocked
);
  logic armed;
  // Each write re-judges both flags, so any other write spoils the unlock
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      armed    <= 1'b0;
      unlocked <= 1'b0;
    end
    else if (wr_any)
    begin
      armed    <= wr_key && (wdata == `FSP_KEY_FIRST); // RL25
      unlocked <= wr_key && armed && (wdata == `FSP_KEY_SECOND); // RL25
    end
  end
endmodule
`default_nettype wire

// [hw/fsp_timer.sv]
/*
  Down counter that times one flash operation.
  Assumes load comes only while the counter is idle.
*/
`default_nettype none
module fsp_timer #(
  parameter int W = 24
) (
  input  wire logic         clk_sys,
  input  wire logic         arst_n,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic              expired
);
  logic [W-1:0] count;
  logic         running;
  // One pulse when the count reaches one
  assign expired = running && (count == W'(1));
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      count   <= '0;
      running <= 1'b0;
    end
    else if (load)
    begin
      count   <= load_val;
      running <= 1'b1;
    end
    else if (running)
    begin
      count   <= count - W'(1);
      running <= !expired;
    end
  end
endmodule
`default_nettype wire

// [hw/fsp_top.sv]
/*
  Run-time self-programming sequencer: control, key and table page
  registers, 64-word holding buffer, table access and timed array
  operations with processor stall.
  Assumes a synchronous flash array that returns read data in the cycle
  after rd, and a core that stops issuing requests while stalled.
*/
// The strobed register port and the placing of the registers were chosen for this implementation.
`default_nettype none
`include "fsp_consts.svh"
module fsp_top #(
  parameter int ROW_CYC   = `FSP_CYC(`FSP_ROW_FRC_CYC),
  parameter int ERASE_CYC = `FSP_CYC(`FSP_ROW_FRC_CYC),
  parameter int WORD_CYC  = `FSP_CYC(`FSP_ROW_FRC_CYC)
) (
  input  wire logic                 clk_sys,
  input  wire logic                 arst_n,
  input  wire logic [1:0]           reg_addr,
  input  wire logic [15:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic [15:0]               reg_rdata,
  input  wire fsp_pkg::fsp_tbl_req_t tbl,
  output logic [15:0]               tbl_rdata,
  output logic                      tbl_done,
  output logic                      cpu_stall,
  output fsp_pkg::fsp_arr_cmd_t      arr_cmd,
  input  wire logic [23:0]          arr_rdata
);
  fsp_pkg::fsp_state_t state;
  fsp_pkg::fsp_state_t next_state;
  fsp_pkg::fsp_op_t    cur_op;
  logic                ctl_start;
  logic                ctl_en;
  logic                ctl_err;
  logic                ctl_erase;
  logic [3:0]          ctl_opc;
  logic [7:0]          table_page;
  logic [23:0]         hold_buf [64];
  logic [23:0]         tbl_last_addr;
  logic [23:0]         cmd_addr;
  logic [23:0]         cmd_wdata;
  logic [5:0]          stream_idx;
  logic                t1;
  logic                t2;
  logic                t_write;
  logic                t_high;
  logic                t_byte;
  logic [15:0]         t_ea;
  logic [15:0]         t_wdata;
  logic                unlocked;
  logic                tmr_expired;

  // Register decode; writes are ignored while an operation runs
  wire idle      = (state == fsp_pkg::FSP_ST_IDLE);
  wire wr_ok     = reg_wr && idle;
  wire ctl_wr    = wr_ok && (reg_addr == `FSP_REG_CTL);
  wire key_wr    = wr_ok && (reg_addr == `FSP_REG_KEY);
  wire page_wr   = wr_ok && (reg_addr == `FSP_REG_PAGE);
  wire start_try = ctl_wr && reg_wdata[`FSP_CTL_START];

  // Operation select from the word being written
  fsp_pkg::fsp_op_t new_op;
  assign new_op = fsp_pkg::fsp_decode(reg_wdata[`FSP_CTL_ERASE], reg_wdata[3:0]); // RL23 RL24

  // Start needs fresh keys, the enable bit and a real operation
  wire start_ok = start_try && unlocked && reg_wdata[`FSP_CTL_EN] && // RL21 RL25
                  (new_op != fsp_pkg::FSP_OP_NONE);
  wire op_end   = (state == fsp_pkg::FSP_ST_WAIT) && tmr_expired;

  fsp_keyguard u_keyguard (
    .clk_sys  (clk_sys),
    .arst_n   (arst_n),
    .wr_any   (wr_ok),
    .wr_key   (key_wr),
    .wdata    (reg_wdata[7:0]),
    .unlocked (unlocked)
  );

  // Target address of the last table write, aligned per operation
  wire [23:0] row_base  = tbl_last_addr & `FSP_ROW_MASK; // RL1 RL3
  wire [23:0] page_base = tbl_last_addr & `FSP_PAGE_MASK; // RL2 RL3
  logic [23:0] start_addr;
  always_comb
  begin
    case (new_op)
      fsp_pkg::FSP_OP_ROW:  start_addr = row_base;
      fsp_pkg::FSP_OP_PAGE: start_addr = page_base;
      fsp_pkg::FSP_OP_BULK: start_addr = 24'h000000;
      default:              start_addr = tbl_last_addr; // RL18
    endcase
  end

  // Streaming control: a row walks all 64 slots, a word takes one
  wire is_row      = (cur_op == fsp_pkg::FSP_OP_ROW);
  wire stream_last = !is_row || (stream_idx == `FSP_LAST_IDX); // RL1
  wire [5:0] start_idx = (new_op == fsp_pkg::FSP_OP_ROW) ? 6'h00 : tbl_last_addr[6:1];
  wire [5:0] next_idx  = stream_idx + 6'h01;
  wire is_erase_op = (new_op == fsp_pkg::FSP_OP_BULK) || (new_op == fsp_pkg::FSP_OP_PAGE) ||
                     (new_op == fsp_pkg::FSP_OP_CFG_ERASE);

  // Sequencer
  always_comb
  begin
    next_state = state;
    case (state)
      fsp_pkg::FSP_ST_IDLE:
        if (start_ok)
          next_state = is_erase_op ? fsp_pkg::FSP_ST_ERASE : fsp_pkg::FSP_ST_STREAM;
      fsp_pkg::FSP_ST_STREAM:
        if (stream_last)
          next_state = fsp_pkg::FSP_ST_WAIT;
      fsp_pkg::FSP_ST_ERASE:
        next_state = fsp_pkg::FSP_ST_WAIT;
      fsp_pkg::FSP_ST_WAIT:
        if (tmr_expired)
          next_state = fsp_pkg::FSP_ST_IDLE;
      default:
        next_state = fsp_pkg::FSP_ST_IDLE;
    endcase
  end

  // Timer load at the last array strobe of an operation
  wire tmr_load = ((state == fsp_pkg::FSP_ST_STREAM) && stream_last) ||
                  (state == fsp_pkg::FSP_ST_ERASE);
  logic [23:0] tmr_val;
  always_comb
  begin
    case (cur_op)
      fsp_pkg::FSP_OP_ROW:  tmr_val = 24'(ROW_CYC); // RL10
      fsp_pkg::FSP_OP_WORD, fsp_pkg::FSP_OP_CFG_PROG: tmr_val = 24'(WORD_CYC);
      default:              tmr_val = 24'(ERASE_CYC);
    endcase
  end

  fsp_timer #(
    .W (24)
  ) u_timer (
    .clk_sys  (clk_sys),
    .arst_n   (arst_n),
    .load     (tmr_load),
    .load_val (tmr_val),
    .expired  (tmr_expired)
  );

  // Stall the core for the whole operation
  assign cpu_stall = !idle; // RL9

  // Error flag: a failed start attempt sets it, a good start clears it
  wire next_err = (start_try && !start_ok) ? 1'b1 : // RL22
                  start_ok ? 1'b0 :
                  ctl_wr ? reg_wdata[`FSP_CTL_ERR] : ctl_err;
  // Start bit stays set until the timer ends the operation
  wire next_start = start_ok || (ctl_start && !op_end); // RL11

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state     <= fsp_pkg::FSP_ST_IDLE;
      ctl_start <= 1'b0;
      ctl_err   <= 1'b0;
    end
    else
    begin
      state     <= next_state;
      ctl_start <= next_start;
      ctl_err   <= next_err;
    end
  end

  // Plain control fields and the table page
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctl_en     <= 1'b0;
      ctl_erase  <= 1'b0;
      ctl_opc    <= 4'h0;
      table_page <= 8'h00;
    end
    else
    begin
      if (ctl_wr)
      begin
        ctl_en    <= reg_wdata[`FSP_CTL_EN]; // RL14
        ctl_erase <= reg_wdata[`FSP_CTL_ERASE];
        ctl_opc   <= reg_wdata[3:0];
      end
      if (page_wr)
        table_page <= reg_wdata[7:0];
    end
  end

  // Read-back; the key register always reads zero
  logic [15:0] rd_mux;
  always_comb
  begin
    case (reg_addr)
      `FSP_REG_CTL:
      begin
        rd_mux = 16'h0000;
        rd_mux[`FSP_CTL_START] = ctl_start;
        rd_mux[`FSP_CTL_EN]    = ctl_en;
        rd_mux[`FSP_CTL_ERR]   = ctl_err;
        rd_mux[`FSP_CTL_ERASE] = ctl_erase;
        rd_mux[3:0]            = ctl_opc;
      end
      `FSP_REG_PAGE: rd_mux = {8'h00, table_page};
      default:       rd_mux = 16'h0000; // RL13
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      reg_rdata <= 16'h0000;
    else if (reg_rd)
      reg_rdata <= rd_mux;
  end

  // Table requests are taken only while idle
  wire        tbl_take = tbl.req && idle; // RL19
  wire [23:0] tbl_addr = {table_page, tbl.ea}; // RL15

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      t1            <= 1'b0;
      t2            <= 1'b0;
      t_write       <= 1'b0;
      t_high        <= 1'b0;
      t_byte        <= 1'b0;
      t_ea          <= 16'h0000;
      t_wdata       <= 16'h0000;
      tbl_last_addr <= 24'h000000;
    end
    else
    begin
      t1 <= tbl_take;
      t2 <= t1 && !t_write;
      if (tbl_take)
      begin
        t_write <= tbl.write;
        t_high  <= tbl.high;
        t_byte  <= tbl.byte_mode;
        t_ea    <= tbl.ea;
        t_wdata <= tbl.wdata;
        if (tbl.write)
          tbl_last_addr <= tbl_addr;
      end
    end
  end

  // Holding buffer: table writes land here, never in the array
  wire [5:0] buf_idx = t_ea[5:0] >> 1;
  wire [5:0] wr_idx  = {t_ea[6], buf_idx[4:0]};
  always_ff @(posedge clk_sys)
  begin
    if (t1 && t_write) // RL7 RL8
    begin
      if (t_high)
      begin
        if (!t_byte || !t_ea[0])
          hold_buf[wr_idx][23:16] <= t_wdata[7:0]; // RL17
      end
      else if (!t_byte)
        hold_buf[wr_idx][15:0] <= t_wdata; // RL16
      else if (t_ea[0])
        hold_buf[wr_idx][15:8] <= t_wdata[7:0];
      else
        hold_buf[wr_idx][7:0] <= t_wdata[7:0];
    end
  end

  // Read formatting; the phantom upper byte reads zero
  wire [15:0] low_fmt  = !t_byte ? arr_rdata[15:0] :
                         {8'h00, t_ea[0] ? arr_rdata[15:8] : arr_rdata[7:0]}; // RL16
  wire [15:0] high_fmt = (t_byte && t_ea[0]) ? 16'h0000 : {8'h00, arr_rdata[23:16]}; // RL17

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tbl_done  <= 1'b0;
      tbl_rdata <= 16'h0000;
    end
    else
    begin
      tbl_done <= (t1 && t_write) || t2; // RL7
      if (t2)
        tbl_rdata <= t_high ? high_fmt : low_fmt;
    end
  end

  // Array address and data stage; strobes follow from state
  wire [23:0] next_cmd_addr = start_ok ? start_addr :
                              (state == fsp_pkg::FSP_ST_STREAM) ? cmd_addr + 24'h000002 :
                              tbl_take ? tbl_addr : cmd_addr;
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cmd_addr   <= 24'h000000;
      cmd_wdata  <= 24'h000000;
      stream_idx <= 6'h00;
      cur_op     <= fsp_pkg::FSP_OP_NONE;
    end
    else
    begin
      cmd_addr <= next_cmd_addr;
      if (start_ok)
      begin
        cur_op     <= new_op;
        stream_idx <= start_idx;
        cmd_wdata  <= hold_buf[start_idx]; // RL4
      end
      else if (state == fsp_pkg::FSP_ST_STREAM)
      begin
        stream_idx <= next_idx;
        cmd_wdata  <= hold_buf[next_idx]; // RL4
      end
    end
  end

  // Array command; only a started operation writes or erases
  always_comb
  begin
    arr_cmd       = '0;
    arr_cmd.rd    = t1 && !t_write;
    arr_cmd.we    = (state == fsp_pkg::FSP_ST_STREAM); // RL8
    arr_cmd.erase = (state == fsp_pkg::FSP_ST_ERASE); // RL2
    arr_cmd.op    = cur_op;
    arr_cmd.addr  = cmd_addr;
    arr_cmd.wdata = cmd_wdata;
  end

  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  logic [6:0] we_cnt;
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      we_cnt <= 7'h00;
    else if (start_ok)
      we_cnt <= 7'h00;
    else if (arr_cmd.we)
      we_cnt <= we_cnt + 7'h01;
  end

  sequence s_tbl_write_done;
    ##2 tbl_done;
  endsequence
  sequence s_quiet_array;
    (!arr_cmd.we && !arr_cmd.erase) [*3];
  endsequence

  property p_stall;
    !idle |-> cpu_stall && ctl_start;
  endproperty
  a_stall: assert property (p_stall) else $error("busy without stall"); // RL9
  property p_key_needed;
    start_try && !unlocked |=> !ctl_start && ctl_err && idle;
  endproperty
  a_key_needed: assert property (p_key_needed) else $error("start without keys"); // RL25
  property p_enable_gate;
    start_try && !reg_wdata[`FSP_CTL_EN] |=> idle ##1 idle;
  endproperty
  a_enable_gate: assert property (p_enable_gate) else $error("ran while disabled"); // RL21
  property p_good_start;
    start_ok |=> ctl_start && !ctl_err && !idle;
  endproperty
  a_good_start: assert property (p_good_start) else $error("good start mishandled"); // RL22
  property p_auto_clear;
    (state == fsp_pkg::FSP_ST_WAIT) && tmr_expired |=> !ctl_start && idle;
  endproperty
  a_auto_clear: assert property (p_auto_clear) else $error("start bit stuck"); // RL11
  property p_tbl_write;
    tbl_take && tbl.write |-> s_tbl_write_done;
  endproperty
  a_tbl_write: assert property (p_tbl_write) else $error("table write not two cycles"); // RL7
  property p_buffer_only;
    tbl_take && tbl.write |-> s_quiet_array;
  endproperty
  a_buffer_only: assert property (p_buffer_only) else $error("table write hit array"); // RL8
  property p_row_len;
    arr_cmd.we && is_row && stream_last |-> we_cnt == 7'h3f;
  endproperty
  a_row_len: assert property (p_row_len) else $error("row not 64 words"); // RL1
  property p_page_align;
    arr_cmd.erase && (cur_op == fsp_pkg::FSP_OP_PAGE) |-> (arr_cmd.addr[9:0] == 10'h000);
  endproperty
  a_page_align: assert property (p_page_align) else $error("page misaligned"); // RL3
  property p_rd_addr;
    tbl_take && !tbl.write |=> arr_cmd.rd && arr_cmd.addr == {$past(table_page), $past(tbl.ea)};
  endproperty
  a_rd_addr: assert property (p_rd_addr) else $error("bad table address"); // RL15
  property p_high_read;
    t2 && t_high |=> tbl_done && (tbl_rdata[15:8] == 8'h00);
  endproperty
  a_high_read: assert property (p_high_read) else $error("phantom byte not zero"); // RL17
  property p_low_read;
    t2 && !t_high && !t_byte |=> tbl_rdata == $past(arr_rdata[15:0]);
  endproperty
  a_low_read: assert property (p_low_read) else $error("low word read wrong"); // RL16
  property p_row_data;
    arr_cmd.we |-> arr_cmd.wdata == hold_buf[arr_cmd.addr[6:1]];
  endproperty
  a_row_data: assert property (p_row_data) else $error("data not from buffer"); // RL4
  property p_row_time;
    tmr_load && is_row |-> tmr_val == 24'(ROW_CYC);
  endproperty
  a_row_time: assert property (p_row_time) else $error("row time wrong"); // RL10
endmodule
`default_nettype wire

// [test/fsp_arr_model.sv]
/*
  Flash array stand-in for the sequencer's array port.
  Assumes one-cycle rd, we and erase strobes on the system clock.
*/
`default_nettype none
module fsp_arr_model (
  input  wire logic                  clk_sys,
  input  wire logic                  arst_n,
  input  wire fsp_pkg::fsp_arr_cmd_t arr_cmd,
  output logic [23:0]                arr_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [23:0] mem [logic [23:0]];
  int          we_cnt;
  int          er_cnt;
  logic [23:0] we_addr;
  logic [23:0] er_addr;
  logic [23:0] rd_addr;

  // Data tied to address bits 15:0, so a wrong offset shows up
  function automatic logic [23:0] pat(input logic [23:0] a);
    return {a[7:0] ^ 8'h3c, a[15:0] ^ 16'h9a5f};
  endfunction

  // Answer one cycle after rd; otherwise toggle so stale data never matches
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      arr_rdata <= 24'h000000;
    else if (arr_cmd.rd)
    begin
      arr_rdata <= pat(arr_cmd.addr);
      rd_addr   <= arr_cmd.addr;
    end
    else
      arr_rdata <= ~arr_rdata;
  end

  // Log programming and erase strobes for the bench
  always @(posedge clk_sys)
  begin
    if (arr_cmd.we)
    begin
      mem[arr_cmd.addr] = arr_cmd.wdata;
      we_addr = arr_cmd.addr;
      we_cnt++;
    end
    if (arr_cmd.erase)
    begin
      er_addr = arr_cmd.addr;
      er_cnt++;
    end
  end
endmodule
`default_nettype wire

// [test/tb_flash_self_programming.sv]
/*
  Self-checking bench for the flash self-programming sequencer.
  Assumes fsp_arr_model on the array port and shortened timer counts.
*/
`default_nettype none
`include "fsp_consts.svh"
module tb_flash_self_programming;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int ROW = 20;
  localparam int ERA = 30;
  localparam int WRD = 25;
  logic                  clk_sys;
  logic                  arst_n;
  logic [1:0]            reg_addr;
  logic [15:0]           reg_wdata;
  logic                  reg_wr;
  logic                  reg_rd;
  logic [15:0]           reg_rdata;
  fsp_pkg::fsp_tbl_req_t tbl;
  logic [15:0]           tbl_rdata;
  logic                  tbl_done;
  logic                  cpu_stall;
  fsp_pkg::fsp_arr_cmd_t arr_cmd;
  logic [23:0]           arr_rdata;
  int                    failures;
  int                    compares;

  fsp_top #(.ROW_CYC(ROW), .ERASE_CYC(ERA), .WORD_CYC(WRD)) fsp_top_inst (
    .clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tbl(tbl),
    .tbl_rdata(tbl_rdata), .tbl_done(tbl_done), .cpu_stall(cpu_stall),
    .arr_cmd(arr_cmd), .arr_rdata(arr_rdata));
  fsp_arr_model fsp_arr_model_inst (.clk_sys(clk_sys), .arst_n(arst_n),
    .arr_cmd(arr_cmd), .arr_rdata(arr_rdata));

  // 100 ns system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %0t %s: saw %h want %h", $time, what, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic tmo();
    failures++;
    $display("[FAIL] %0t wait ran out", $time);
    conclude();
  endtask

  task automatic clr();
    fsp_arr_model_inst.we_cnt = 0;
    fsp_arr_model_inst.er_cnt = 0;
  endtask

  // A spare edge between calls keeps each strobe a clean single pulse
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, output logic [15:0] v);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  // Request held up to its taking edge; k counts edges until done
  task automatic tbl_op(input logic w, input logic hi, input logic bm,
                        input logic [15:0] ea, input logic [15:0] wd,
                        output logic [15:0] v, output int k);
    @(posedge clk_sys);
    tbl <= {1'b1, w, hi, bm, ea, wd};
    @(posedge clk_sys);
    tbl.req <= 1'b0;
    #1;
    for (k = 1; k < 8 && tbl_done !== 1'b1; k++)
    begin
      @(posedge clk_sys);
      #1;
    end
    if (k == 8)
      tmo();
    v = tbl_rdata;
  endtask

  task automatic keys();
    wr(`FSP_REG_KEY, 16'h0055);
    wr(`FSP_REG_KEY, 16'h00aa);
  endtask

  // Stall length in cycles; zero when the start was refused
  task automatic run(output int n);
    int k;
    n = 0;
    for (k = 0; k < 3000; k++)
    begin
      #1;
      if (cpu_stall === 1'b1)
        n++;
      else if (n > 0 || k > 8)
        break;
      @(posedge clk_sys);
    end
    if (k == 3000)
      tmo();
  endtask

  task automatic t_regs();
    logic [15:0] v;
    rd(`FSP_REG_CTL, v);
    chk(v, 16'h0000, "control reset");
    wr(`FSP_REG_KEY, 16'h0055);
    rd(`FSP_REG_KEY, v);
    chk(v, 16'h0000, "key readback");
    rd(2'h3, v);
    chk(v, 16'h0000, "unmapped read");
    wr(`FSP_REG_PAGE, 16'h00a5);
    rd(`FSP_REG_PAGE, v);
    chk(v, 16'h00a5, "page readback");
    $display("test regs done");
  endtask

  task automatic t_table();
    logic [15:0] ea [5] = '{16'h3456, 16'h3456, 16'h3457, 16'h3456, 16'h3457};
    logic [4:0]  his = 5'b11000;
    logic [4:0]  bms = 5'b10110;
    logic [23:0] p;
    logic [15:0] v;
    logic [15:0] e;
    int          k;
    wr(`FSP_REG_PAGE, 16'h0012);
    clr();
    tbl_op(1'b1, 1'b0, 1'b0, 16'h3456, 16'hbeef, v, k);
    chk(k <= 2, 1, "write time");
    for (int i = 0; i < 5; i++)
    begin
      p = fsp_arr_model_inst.pat({8'h12, ea[i]});
      e = his[i] ? (bms[i] ? 16'h0000 : {8'h00, p[23:16]})
                 : (!bms[i] ? p[15:0] : {8'h00, ea[i][0] ? p[15:8] : p[7:0]});
      tbl_op(1'b0, his[i], bms[i], ea[i], 16'h0000, v, k);
      chk(v, e, "table read data");
      chk(k <= 3, 1, "read time");
      if (i < 4)
        chk(fsp_arr_model_inst.rd_addr, {8'h12, ea[i]}, "table address");
    end
    chk(fsp_arr_model_inst.we_cnt, 0, "array untouched");
    $display("test table done");
  endtask

  // Missing keys, enable off, spoiled unlock, wrong key order, no-op code
  task automatic t_fail();
    logic [15:0] ctl [5] = '{16'hc001, 16'h8001, 16'hc001, 16'hc001, 16'hc043};
    logic [15:0] v;
    int          n;
    for (int i = 0; i < 5; i++)
    begin
      clr();
      if (i == 3)
      begin
        wr(`FSP_REG_KEY, 16'h00aa);
        wr(`FSP_REG_KEY, 16'h0055);
      end
      else if (i > 0)
        keys();
      if (i == 2)
        wr(`FSP_REG_PAGE, 16'h0001);
      wr(`FSP_REG_CTL, ctl[i]);
      run(n);
      chk(n, 0, "refused start");
      rd(`FSP_REG_CTL, v);
      chk(v & 16'ha000, 16'h2000, "refused flags");
      chk(fsp_arr_model_inst.we_cnt + fsp_arr_model_inst.er_cnt, 0, "array untouched");
    end
    $display("test refusals done");
  endtask

  task automatic t_row();
    logic [15:0] v;
    logic [15:0] ea;
    int          n;
    int          k;
    wr(`FSP_REG_PAGE, 16'h0001);
    clr();
    for (int i = 0; i < 64; i++)
    begin
      ea = 16'h0180 + 16'(2 * i);
      tbl_op(1'b1, 1'b0, 1'b0, ea, {i[7:0], ~i[7:0]}, v, k);
      tbl_op(1'b1, 1'b1, 1'b0, ea, {8'h00, i[7:0] ^ 8'ha5}, v, k);
      chk(k <= 2, 1, "write time");
    end
    chk(fsp_arr_model_inst.we_cnt, 0, "buffer load only");
    keys();
    wr(`FSP_REG_CTL, 16'hc001);
    run(n);
    chk(n >= 64 + ROW && n <= 68 + ROW, 1, "row stall");
    chk(fsp_arr_model_inst.we_cnt, 64, "row words");
    for (int i = 0; i < 64; i++)
    begin
      ea = 16'h0180 + 16'(2 * i);
      chk(fsp_arr_model_inst.mem[{8'h01, ea}], {i[7:0] ^ 8'ha5, i[7:0], ~i[7:0]}, "row data");
    end
    rd(`FSP_REG_CTL, v);
    chk(v, 16'h4001, "start cleared");
    $display("test row done");
  endtask

  // Bulk, page and configuration erase, then word and config byte program
  task automatic t_ops();
    logic [15:0] ctl [5] = '{16'hc04f, 16'hc042, 16'hc040, 16'hc003, 16'hc000};
    logic [23:0] adr [5] = '{24'h000000, 24'h010800, 24'h000000, 24'h010a46, 24'h010a46};
    int          cyc [5] = '{ERA, ERA, ERA, WRD, WRD};
    logic [15:0] v;
    int          n;
    int          k;
    for (int i = 0; i < 5; i++)
    begin
      tbl_op(1'b1, 1'b0, 1'b0, 16'h0a46, 16'h1234, v, k);
      clr();
      keys();
      wr(`FSP_REG_CTL, ctl[i]);
      run(n);
      chk(n >= cyc[i] && n <= cyc[i] + 4, 1, "op stall");
      chk(fsp_arr_model_inst.er_cnt, i < 3, "erase strobes");
      chk(fsp_arr_model_inst.we_cnt, i >= 3, "word strobes");
      chk(arr_cmd.op, i + 1 + (i == 4), "op code");
      if (i != 2)
        chk(i < 3 ? fsp_arr_model_inst.er_addr : fsp_arr_model_inst.we_addr, adr[i],
            "target");
      rd(`FSP_REG_CTL, v);
      chk(v, ctl[i] & 16'h7fff, "start cleared");
    end
    $display("test ops done");
  endtask

  // Reset for 12 cycles, then run every scenario
  initial
  begin
    arst_n    = 1'b0;
    reg_addr  = 2'h0;
    reg_wdata = 16'h0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    tbl       = '0;
    failures  = 0;
    compares  = 0;
    repeat (12) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_regs();
    t_table();
    t_fail();
    t_row();
    t_ops();
    conclude();
  end
endmodule
`default_nettype wire
